// ===== hub_window_regs.sv
// Hub register window base and function visibility registers of the host
// bridge, reached by configuration dword accesses, plus the window decode.
// Assumes lock and fuse inputs come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none

module hub_window_regs #(
  parameter bit DUAL_PORT_VARIANT = 1'b1
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        cfg_req,
  input  wire logic        cfg_we,
  input  wire logic [7:0]  cfg_addr,
  input  wire logic [3:0]  cfg_be,
  input  wire logic [31:0] cfg_wdata,
  output logic      [31:0] cfg_rdata,
  output logic             cfg_ack,
  input  wire logic        mem_req,
  input  wire logic [35:0] mem_addr,
  output logic             mem_claim,
  output logic             mem_block,
  input  wire logic        trusted_mode,
  input  wire logic        engine_security_lock,
  input  wire logic [63:0] capability_fuses,
  output logic             root_port_visible,
  output logic             second_root_port_visible,
  output logic             engine_func0_visible,
  output logic             engine_func1_visible,
  output logic             engine_func2_visible,
  output logic             engine_func3_visible
);

  // ==========================================================================
  // Elaboration check
  if (DUAL_PORT_VARIANT !== 1'b0 && DUAL_PORT_VARIANT !== 1'b1) begin : g_chk
    $error("DUAL_PORT_VARIANT must be 0 or 1");
  end

  // ==========================================================================
  // State
  typedef struct packed {
    logic [hub_cfg_pkg::BASE_W-1:0] hub_window_base;
    logic                           hub_window_enable;
    logic                           second_root_port_enable;
    logic                           engine_func3_enable;
    logic                           engine_func2_enable;
    logic                           engine_func1_enable;
    logic                           engine_func0_enable;
    logic                           root_port_enable;
    logic [31:0]                    rdata;
    logic                           ack;
    logic                           claim;
    logic                           block;
    logic                           vis_rp;
    logic                           vis_p2;
    logic                           vis_f0;
    logic                           vis_f1;
    logic                           vis_f2;
    logic                           vis_f3;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  logic        open_hit;
  logic [31:0] base_lo_cur;
  logic [31:0] base_hi_cur;
  logic [31:0] vis_cur;
  logic [31:0] wmask;
  logic [31:0] lo_new;
  logic [31:0] hi_new;
  logic [31:0] vis_new;
  logic        win_hit;
  logic        locked;
  logic        f0_eff;

  function automatic logic [31:0] be_to_mask(input logic [3:0] be);
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{be[i]}};
    end
    return m;
  endfunction

  // ==========================================================================
  // Open range lookup
  window_open_range u_open (
    .offset   (mem_addr[13:0]),
    .open_hit (open_hit)
  );

  // ==========================================================================
  // Next state
  always_comb begin
    st_nxt      = st_r;
    base_lo_cur = {st_r.hub_window_base[hub_cfg_pkg::BASE_LO_W-1:0],
                   {(hub_cfg_pkg::BASE_LSB-1){1'b0}},
                   st_r.hub_window_enable};
    base_hi_cur = {{(32-hub_cfg_pkg::BASE_HI_W){1'b0}},
                   st_r.hub_window_base[hub_cfg_pkg::BASE_W-1:
                                        hub_cfg_pkg::BASE_LO_W]};
    vis_cur     = hub_cfg_pkg::VIS_CONST_MASK & hub_cfg_pkg::VIS_RESET;
    vis_cur[hub_cfg_pkg::VIS_RP_BIT] = st_r.root_port_enable;
    vis_cur[hub_cfg_pkg::VIS_F0_BIT] = st_r.engine_func0_enable;
    vis_cur[hub_cfg_pkg::VIS_F1_BIT] = st_r.engine_func1_enable;
    vis_cur[hub_cfg_pkg::VIS_F2_BIT] = st_r.engine_func2_enable;
    vis_cur[hub_cfg_pkg::VIS_F3_BIT] = st_r.engine_func3_enable;
    vis_cur[hub_cfg_pkg::VIS_P2_BIT] = st_r.second_root_port_enable &
                                       DUAL_PORT_VARIANT;
    wmask       = be_to_mask(cfg_be);
    lo_new      = (base_lo_cur & ~wmask) | (cfg_wdata & wmask);
    hi_new      = (base_hi_cur & ~wmask) | (cfg_wdata & wmask);
    vis_new     = (vis_cur & ~wmask) | (cfg_wdata & wmask);

    st_nxt.ack   = cfg_req;
    st_nxt.rdata = 32'h0000_0000;
    if (cfg_req && !cfg_we) begin
      case (cfg_addr)
        hub_cfg_pkg::CFG_OFF_BASE_LO: st_nxt.rdata = base_lo_cur;
        hub_cfg_pkg::CFG_OFF_BASE_HI: st_nxt.rdata = base_hi_cur;
        hub_cfg_pkg::CFG_OFF_VIS:     st_nxt.rdata = vis_cur;
        default:                      st_nxt.rdata = 32'h0000_0000;
      endcase
    end

    // Trusted mode freezes every writable bit; the engine lock does not.
    if (cfg_req && cfg_we && !trusted_mode) begin
      case (cfg_addr)
        hub_cfg_pkg::CFG_OFF_BASE_LO: begin
          st_nxt.hub_window_base[hub_cfg_pkg::BASE_LO_W-1:0] =
            lo_new[31:hub_cfg_pkg::BASE_LSB];
          st_nxt.hub_window_enable = lo_new[hub_cfg_pkg::WIN_EN_BIT];
        end
        hub_cfg_pkg::CFG_OFF_BASE_HI: begin
          st_nxt.hub_window_base[hub_cfg_pkg::BASE_W-1:
                                 hub_cfg_pkg::BASE_LO_W] =
            hi_new[hub_cfg_pkg::BASE_HI_W-1:0];
        end
        hub_cfg_pkg::CFG_OFF_VIS: begin
          st_nxt.root_port_enable    = vis_new[hub_cfg_pkg::VIS_RP_BIT];
          st_nxt.engine_func0_enable = vis_new[hub_cfg_pkg::VIS_F0_BIT];
          st_nxt.engine_func1_enable = vis_new[hub_cfg_pkg::VIS_F1_BIT];
          st_nxt.engine_func2_enable = vis_new[hub_cfg_pkg::VIS_F2_BIT];
          st_nxt.engine_func3_enable = vis_new[hub_cfg_pkg::VIS_F3_BIT];
          if (DUAL_PORT_VARIANT) begin
            st_nxt.second_root_port_enable =
              vis_new[hub_cfg_pkg::VIS_P2_BIT];
          end
        end
        default: begin
        end
      endcase
    end

    // The window decodes registers only; no data is stored for a claim.
    win_hit = st_r.hub_window_enable &&
              (mem_addr[hub_cfg_pkg::BASE_MSB:hub_cfg_pkg::BASE_LSB] ==
               st_r.hub_window_base);
    locked  = trusted_mode || engine_security_lock;
    st_nxt.claim = mem_req && win_hit && (!locked || open_hit);
    st_nxt.block = mem_req && win_hit && locked && !open_hit;

    f0_eff = st_r.engine_func0_enable &&
             !capability_fuses[hub_cfg_pkg::FUSE_NO_ENGINE];
    st_nxt.vis_rp = st_r.root_port_enable;
    st_nxt.vis_p2 = st_r.second_root_port_enable && DUAL_PORT_VARIANT;
    st_nxt.vis_f0 = f0_eff;
    st_nxt.vis_f1 = st_r.engine_func1_enable && f0_eff;
    st_nxt.vis_f2 = st_r.engine_func2_enable && f0_eff &&
                    !capability_fuses[hub_cfg_pkg::FUSE_NO_F23];
    st_nxt.vis_f3 = st_r.engine_func3_enable && f0_eff &&
                    !capability_fuses[hub_cfg_pkg::FUSE_NO_F23];
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_r                         <= '0;
      st_r.root_port_enable        <=
        hub_cfg_pkg::VIS_RESET[hub_cfg_pkg::VIS_RP_BIT];
      st_r.engine_func0_enable     <=
        hub_cfg_pkg::VIS_RESET[hub_cfg_pkg::VIS_F0_BIT];
      st_r.engine_func1_enable     <=
        hub_cfg_pkg::VIS_RESET[hub_cfg_pkg::VIS_F1_BIT];
      st_r.engine_func2_enable     <=
        hub_cfg_pkg::VIS_RESET[hub_cfg_pkg::VIS_F2_BIT];
      st_r.engine_func3_enable     <=
        hub_cfg_pkg::VIS_RESET[hub_cfg_pkg::VIS_F3_BIT];
      st_r.second_root_port_enable <=
        hub_cfg_pkg::VIS_RESET[hub_cfg_pkg::VIS_P2_BIT];
    end else begin
      st_r <= st_nxt;
    end
  end

  assign cfg_rdata                = st_r.rdata;
  assign cfg_ack                  = st_r.ack;
  assign mem_claim                = st_r.claim;
  assign mem_block                = st_r.block;
  assign root_port_visible        = st_r.vis_rp;
  assign second_root_port_visible = st_r.vis_p2;
  assign engine_func0_visible     = st_r.vis_f0;
  assign engine_func1_visible     = st_r.vis_f1;
  assign engine_func2_visible     = st_r.vis_f2;
  assign engine_func3_visible     = st_r.vis_f3;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  property p_disabled_no_claim;
    !st_r.hub_window_enable |=> !mem_claim && !mem_block;
  endproperty
  a_disabled_no_claim: assert property (p_disabled_no_claim)
    else $error("window claimed while disabled");

  property p_claim_match;
    mem_req && st_r.hub_window_enable &&
    mem_addr[35:14] == st_r.hub_window_base && !trusted_mode &&
    !engine_security_lock |=> mem_claim;
  endproperty
  a_claim_match: assert property (p_claim_match)
    else $error("matching window access not claimed");

  property p_lock_freeze;
    trusted_mode |=> $stable(st_r.hub_window_base) &&
                     $stable(st_r.hub_window_enable) &&
                     $stable(st_r.engine_func0_enable) &&
                     $stable(st_r.root_port_enable);
  endproperty
  a_lock_freeze: assert property (p_lock_freeze)
    else $error("locked bit changed in trusted mode");

  // Offsets below the first open range are always closed under lock.
  property p_block_closed;
    mem_req && st_r.hub_window_enable && engine_security_lock &&
    mem_addr[35:14] == st_r.hub_window_base &&
    mem_addr[13:0] < 14'h02B8 |=> !mem_claim && mem_block;
  endproperty
  a_block_closed: assert property (p_block_closed)
    else $error("locked low range access claimed");

  property p_open_throttle;
    mem_req && st_r.hub_window_enable && trusted_mode &&
    mem_addr[35:14] == st_r.hub_window_base &&
    mem_addr[13:3] == 11'h057 |=> mem_claim && !mem_block;
  endproperty
  a_open_throttle: assert property (p_open_throttle)
    else $error("throttle range blocked under lock");

  property p_open_expansion;
    mem_req && st_r.hub_window_enable && engine_security_lock &&
    mem_addr[35:14] == st_r.hub_window_base &&
    mem_addr[13:12] == 2'b11 |=> mem_claim;
  endproperty
  a_open_expansion: assert property (p_open_expansion)
    else $error("expansion range blocked under lock");

  property p_open_chan1;
    mem_req && st_r.hub_window_enable && trusted_mode &&
    mem_addr[35:14] == st_r.hub_window_base &&
    mem_addr[13:3] == 11'h0D7 |=> mem_claim && !mem_block;
  endproperty
  a_open_chan1: assert property (p_open_chan1)
    else $error("channel 1 throttle range blocked under lock");

  property p_open_thermal;
    mem_req && st_r.hub_window_enable && engine_security_lock &&
    mem_addr[35:14] == st_r.hub_window_base &&
    mem_addr[13:4] >= 10'h0CD && mem_addr[13:4] <= 10'h0CF
    |=> mem_claim && !mem_block;
  endproperty
  a_open_thermal: assert property (p_open_thermal)
    else $error("thermal control range blocked under lock");

  property p_unmapped_zero;
    cfg_req && !cfg_we && cfg_addr != 8'h48 && cfg_addr != 8'h4C &&
    cfg_addr != 8'h54 |=> cfg_ack && cfg_rdata == 32'h0000_0000;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero)
    else $error("unmapped offset read not zero");

  property p_hi_reserved;
    cfg_req && !cfg_we && cfg_addr == 8'h4C |=>
      cfg_ack && cfg_rdata[31:4] == 28'h000_0000;
  endproperty
  a_hi_reserved: assert property (p_hi_reserved)
    else $error("base high reserved bits not zero");

  property p_f0_gates_others;
    !engine_func0_visible |-> !engine_func1_visible &&
                              !engine_func2_visible && !engine_func3_visible;
  endproperty
  a_f0_gates_others: assert property (p_f0_gates_others)
    else $error("engine function visible without function 0");

  property p_fuse57;
    capability_fuses[57] |=> !engine_func0_visible && !engine_func1_visible;
  endproperty
  a_fuse57: assert property (p_fuse57)
    else $error("engine functions visible with engine absent");

  property p_fuse56;
    capability_fuses[56] |=> !engine_func2_visible && !engine_func3_visible;
  endproperty
  a_fuse56: assert property (p_fuse56)
    else $error("functions 2 and 3 visible with fuse 56 set");

  property p_host_bit;
    cfg_req && !cfg_we && cfg_addr == 8'h54 |=> cfg_ack && cfg_rdata[0] &&
      cfg_rdata[31:14] == 18'h00000 && cfg_rdata[12:10] == 3'b000;
  endproperty
  a_host_bit: assert property (p_host_bit)
    else $error("visibility readback wrong constant bits");

  property p_rp_visible;
    cfg_req && cfg_we && cfg_addr == 8'h54 && cfg_be[0] && !trusted_mode
    |=> ##1 root_port_visible == $past(cfg_wdata[1], 2);
  endproperty
  a_rp_visible: assert property (p_rp_visible)
    else $error("root port visibility does not follow write");

  c_claim:   cover property (mem_req ##1 mem_claim);
  c_block:   cover property (mem_req ##1 mem_block);
  c_frozen:  cover property (cfg_req && cfg_we && trusted_mode);
  c_hidden:  cover property (!engine_func0_visible ##1 engine_func0_visible);

endmodule

`default_nettype wire

// ===== hub_cfg_pkg.sv
// Constants shared by the hub window base and function visibility registers.
// Assumes configuration offsets are byte offsets of aligned dwords.
package hub_cfg_pkg;

  // ==========================================================================
  // Configuration offsets
  localparam logic [7:0]  CFG_OFF_BASE_LO = 8'h48;
  localparam logic [7:0]  CFG_OFF_BASE_HI = 8'h4C;
  localparam logic [7:0]  CFG_OFF_VIS     = 8'h54;

  // ==========================================================================
  // Window base layout
  localparam int          BASE_LSB        = 14;
  localparam int          BASE_MSB        = 35;
  localparam int          BASE_W          = BASE_MSB - BASE_LSB + 1;
  localparam int          BASE_LO_W       = 32 - BASE_LSB;
  localparam int          BASE_HI_W       = BASE_W - BASE_LO_W;
  localparam int          WIN_EN_BIT      = 0;
  localparam logic [63:0] BASE_RESET      = 64'h0000_0000_0000_0000;

  // ==========================================================================
  // Visibility register layout
  localparam int          VIS_HOST_BIT    = 0;
  localparam int          VIS_RP_BIT      = 1;
  localparam int          VIS_F0_BIT      = 6;
  localparam int          VIS_F1_BIT      = 7;
  localparam int          VIS_F2_BIT      = 8;
  localparam int          VIS_F3_BIT      = 9;
  localparam int          VIS_P2_BIT      = 13;
  localparam logic [31:0] VIS_RESET       = 32'h0000_23DB;
  localparam logic [31:0] VIS_CONST_MASK  = 32'h0000_003D;

  // ==========================================================================
  // Capability fuse bits
  localparam int          FUSE_NO_ENGINE  = 57;
  localparam int          FUSE_NO_F23     = 56;

  // ==========================================================================
  // Window ranges that stay open under lock
  localparam logic [13:0] OPEN0_LO        = 14'h02B8;
  localparam logic [13:0] OPEN0_HI        = 14'h02BF;
  localparam logic [13:0] OPEN1_LO        = 14'h06B8;
  localparam logic [13:0] OPEN1_HI        = 14'h06BF;
  localparam logic [13:0] OPEN2_LO        = 14'h0CD0;
  localparam logic [13:0] OPEN2_HI        = 14'h0CFF;
  localparam logic [13:0] OPEN3_LO        = 14'h3000;
  localparam logic [13:0] OPEN3_HI        = 14'h3FFF;

endpackage

// ===== window_open_range.sv
// Decides whether a window offset falls in a range left open under lock.
// Assumes a 14-bit offset inside the 16 KB window; purely combinational.
`timescale 1ns/1ps
`default_nettype none

module window_open_range (
  input  wire logic [13:0] offset,
  output logic             open_hit
);

  // ==========================================================================
  // Range compare
  always_comb begin
    open_hit = ((offset >= hub_cfg_pkg::OPEN0_LO) &&
                (offset <= hub_cfg_pkg::OPEN0_HI)) ||
               ((offset >= hub_cfg_pkg::OPEN1_LO) &&
                (offset <= hub_cfg_pkg::OPEN1_HI)) ||
               ((offset >= hub_cfg_pkg::OPEN2_LO) &&
                (offset <= hub_cfg_pkg::OPEN2_HI)) ||
               ((offset >= hub_cfg_pkg::OPEN3_LO) &&
                (offset <= hub_cfg_pkg::OPEN3_HI));
  end

endmodule

`default_nettype wire

// ===== cfg_host_model.sv
// Host side of the configuration bus: issues one dword access at a time.
// Assumes the block answers with cfg_ack one cycle after the taken edge.
`timescale 1ns/1ps
`default_nettype none

module cfg_host_model (
  input  wire logic        clk,
  input  wire logic [31:0] cfg_rdata,
  input  wire logic        cfg_ack,
  output logic             cfg_req,
  output logic             cfg_we,
  output logic      [7:0]  cfg_addr,
  output logic      [3:0]  cfg_be,
  output logic      [31:0] cfg_wdata
);
  initial begin
    cfg_req   = 1'b0;
    cfg_we    = 1'b0;
    cfg_addr  = 8'h00;
    cfg_be    = 4'h0;
    cfg_wdata = 32'h0000_0000;
  end

  // ==========================================================================
  // One access
  // Released qualifiers show the inverse of their last value, so a block
  // that samples them outside the request cannot see a convenient copy.
  task automatic access(input logic we, input logic [7:0] addr,
                        input logic [3:0] be, input logic [31:0] wdata,
                        output logic [31:0] rdata, output logic ok);
    int i;
    ok    = 1'b0;
    rdata = 32'h0000_0000;
    @(posedge clk);
    #1;
    cfg_req   = 1'b1;
    cfg_we    = we;
    cfg_addr  = addr;
    cfg_be    = be;
    cfg_wdata = wdata;
    @(posedge clk);
    #1;
    cfg_req   = 1'b0;
    cfg_we    = ~we;
    cfg_addr  = ~addr;
    cfg_be    = ~be;
    cfg_wdata = ~wdata;
    for (i = 0; i < 4 && !ok; i++) begin
      if (cfg_ack === 1'b1) begin
        ok    = 1'b1;
        rdata = cfg_rdata;
      end else begin
        @(posedge clk);
        #1;
      end
    end
  endtask
endmodule

`default_nettype wire

// ===== hub_window_regs_tb.sv
// Self-checking bench for the window base and function visibility registers.
// Assumes the host model drives the configuration bus; bench drives the rest.
`timescale 1ns/1ps
`default_nettype none

module hub_window_regs_tb;
  logic        clk;
  logic        rst_b;
  logic        cfg_req;
  logic        cfg_we;
  logic [7:0]  cfg_addr;
  logic [3:0]  cfg_be;
  logic [31:0] cfg_wdata;
  logic [31:0] cfg_rdata;
  logic        cfg_ack;
  logic        mem_req;
  logic [35:0] mem_addr;
  logic        mem_claim;
  logic        mem_block;
  logic        trusted_mode;
  logic        engine_security_lock;
  logic [63:0] capability_fuses;
  wire  [5:0]  vis;
  wire  [31:0] rdata_v0;
  wire         p2_v0;
  int          errors;
  int          n_tests;
  logic [35:0] base;
  logic [13:0] offs [12];
  logic        opn  [12];

  hub_window_regs #(.DUAL_PORT_VARIANT(1'b1)) u_dut (
    .clk(clk), .rst_b(rst_b), .cfg_req(cfg_req), .cfg_we(cfg_we),
    .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack), .mem_req(mem_req),
    .mem_addr(mem_addr), .mem_claim(mem_claim), .mem_block(mem_block),
    .trusted_mode(trusted_mode),
    .engine_security_lock(engine_security_lock),
    .capability_fuses(capability_fuses),
    .root_port_visible(vis[5]), .second_root_port_visible(vis[4]),
    .engine_func0_visible(vis[3]), .engine_func1_visible(vis[2]),
    .engine_func2_visible(vis[1]), .engine_func3_visible(vis[0]));

  cfg_host_model u_host (
    .clk(clk), .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack), .cfg_req(cfg_req),
    .cfg_we(cfg_we), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
    .cfg_wdata(cfg_wdata));

  // The single-port variant shares the bus; only its read data and its
  // second-port visibility are watched, so the variant gate is exercised.
  hub_window_regs #(.DUAL_PORT_VARIANT(1'b0)) u_dut_v0 (
    .clk(clk), .rst_b(rst_b), .cfg_req(cfg_req), .cfg_we(cfg_we),
    .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
    .cfg_rdata(rdata_v0), .cfg_ack(), .mem_req(mem_req),
    .mem_addr(mem_addr), .mem_claim(), .mem_block(),
    .trusted_mode(trusted_mode),
    .engine_security_lock(engine_security_lock),
    .capability_fuses(capability_fuses),
    .root_port_visible(), .second_root_port_visible(p2_v0),
    .engine_func0_visible(), .engine_func1_visible(),
    .engine_func2_visible(), .engine_func3_visible());

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ==========================================================================
  // Tasks
  task automatic results;
    $display("tests %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic acc(input logic we, input logic [7:0] addr,
                     input logic [3:0] be, input logic [31:0] wdata,
                     output logic [31:0] rdata);
    logic ok;
    u_host.access(we, addr, be, wdata, rdata, ok);
    if (!ok) begin
      errors++;
      $display("ERROR cfg_ack expected 1 seen 0");
      results();
    end
  endtask

  task automatic wr(input logic [7:0] addr, input logic [3:0] be,
                    input logic [31:0] data);
    logic [31:0] d;
    acc(1'b1, addr, be, data, d);
  endtask

  task automatic rd(input string what, input logic [7:0] addr,
                    input logic [31:0] exp);
    logic [31:0] d;
    acc(1'b0, addr, 4'hF, 32'h0000_0000, d);
    chk(what, d, exp);
  endtask

  // Expects {mem_claim, mem_block} one cycle after the taken edge.
  task automatic mem_chk(input logic [35:0] addr, input logic [1:0] exp);
    @(posedge clk);
    #1;
    mem_req  = 1'b1;
    mem_addr = addr;
    @(posedge clk);
    #1;
    mem_req  = 1'b0;
    mem_addr = ~addr;
    chk("claim_block", {30'h0, mem_claim, mem_block}, {30'h0, exp});
  endtask

  task automatic vis_chk(input logic [5:0] exp);
    repeat (2) @(posedge clk);
    #1;
    chk("visible", {26'h0, vis}, {26'h0, exp});
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    errors = 0;
    n_tests = 0;
    rst_b = 1'b0;
    mem_req = 1'b0;
    mem_addr = 36'h0_0000_0000;
    trusted_mode = 1'b0;
    engine_security_lock = 1'b0;
    capability_fuses = 64'h0000_0000_0000_0000;
    offs = '{14'h0000, 14'h02B7, 14'h02B8, 14'h02BF, 14'h02C0, 14'h06B8,
             14'h06BF, 14'h0CD0, 14'h0CFF, 14'h0D00, 14'h3000, 14'h3FFF};
    opn  = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1,
             1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
    repeat (4) @(posedge clk);
    #1;
    rst_b = 1'b1;
    vis_chk(6'b111111);
    rd("base_lo", 8'h48, 32'h0000_0000);
    rd("base_hi", 8'h4C, 32'h0000_0000);
    rd("vis_reg", 8'h54, 32'h0000_23DB);
    // The second instance answers the same read in the same cycle.
    chk("vis_reg_v0", rdata_v0, 32'h0000_03DB);
    chk("p2_v0", {31'h0, p2_v0}, 32'h0000_0000);
    mem_chk(36'h0_0000_0010, 2'b00);
    // Reserved bits stay zero even when written with ones.
    wr(8'h48, 4'hF, 32'hFFFF_FFFE);
    wr(8'h4C, 4'hF, 32'hFFFF_FFFF);
    rd("base_lo", 8'h48, 32'hFFFF_C000);
    rd("base_hi", 8'h4C, 32'h0000_000F);
    base = 36'h5_0001_C000;
    wr(8'h4C, 4'hF, 32'h0000_0005);
    wr(8'h48, 4'hF, 32'h0001_C000);
    mem_chk(base, 2'b00);
    wr(8'h48, 4'hF, 32'h0001_C001);
    rd("base_lo", 8'h48, 32'h0001_C001);
    mem_chk(base + 36'h0_0000_3FFC, 2'b10);
    mem_chk(base - 36'h0_0000_0004, 2'b00);
    mem_chk(base + 36'h0_0000_4000, 2'b00);
    mem_chk(base ^ 36'h8_0000_0000, 2'b00);
    for (int k = 0; k < 2; k++) begin
      trusted_mode = (k == 1);
      engine_security_lock = (k == 0);
      for (int i = 0; i < 12; i++) begin
        mem_chk(base + {22'h0, offs[i]}, opn[i] ? 2'b10 : 2'b01);
      end
    end
    // Trusted mode is still on: every write must be ignored but acked.
    wr(8'h54, 4'hF, 32'h0000_0000);
    wr(8'h48, 4'hF, 32'h0000_0000);
    rd("vis_reg", 8'h54, 32'h0000_23DB);
    rd("base_lo", 8'h48, 32'h0001_C001);
    trusted_mode = 1'b0;
    mem_chk(base, 2'b10);
    wr(8'h54, 4'hF, 32'h0000_0000);
    rd("vis_reg", 8'h54, 32'h0000_0019);
    vis_chk(6'b000000);
    wr(8'h54, 4'hF, 32'h0000_0380);
    rd("vis_reg", 8'h54, 32'h0000_0399);
    vis_chk(6'b000000);
    wr(8'h54, 4'hF, 32'hFFFF_FFFF);
    rd("vis_reg", 8'h54, 32'h0000_23DB);
    chk("vis_reg_v0", rdata_v0, 32'h0000_03DB);
    vis_chk(6'b111111);
    chk("p2_v0", {31'h0, p2_v0}, 32'h0000_0000);
    // Byte 0 alone clears the root port and engine functions 0 and 1.
    wr(8'h54, 4'h1, 32'h0000_0000);
    rd("vis_reg", 8'h54, 32'h0000_2319);
    vis_chk(6'b010000);
    wr(8'h54, 4'hF, 32'h0000_23C2);
    capability_fuses[57] = 1'b1;
    vis_chk(6'b110000);
    capability_fuses = 64'h0100_0000_0000_0000;
    vis_chk(6'b111100);
    capability_fuses = 64'h0000_0000_0000_0000;
    vis_chk(6'b111111);
    wr(8'h50, 4'hF, 32'hFFFF_FFFF);
    rd("unmapped", 8'h50, 32'h0000_0000);
    results();
  end
endmodule

`default_nettype wire
